// File: hw/otp_sec_pkg.sv
// Constants and types shared by the security, store and scan logic.
package otp_sec_pkg;
  // Store geometry: four sectors of 512 rows of 32-bit words.
  localparam int SECTORS = 4;
  localparam int ROWS = 512;
  localparam int WORD_W = 32;
  localparam int ROW_W = 9;
  localparam int ADDR_W = 11;
  localparam int DATA_WORDS = SECTORS * ROWS;
  // Extra fuse row that holds the security word, just above the data rows.
  localparam logic [11:0] SEC_ROW = 12'h800;
  localparam logic [11:0] LAST_ROW = 12'h7FF;
  // Resource numbers of the three programming ports.
  localparam logic [23:0] RES_OTP_ADDR = 24'h100200;
  localparam logic [23:0] RES_OTP_DATA = 24'h200100;
  localparam logic [23:0] RES_OTP_CTL = 24'h100300;
  localparam int PORT_ADDR_W = 16;
  localparam int PORT_CTL_W = 16;
  // Control port bits.
  localparam int CTL_PROG = 0;
  localparam int CTL_PROG_SEC = 1;
  localparam int CTL_READ = 2;
  // Security word bit positions.
  localparam int SEC_JTAG_DIS = 0;
  localparam int SEC_LINK_DIS = 1;
  localparam int SEC_BOOT_OTP = 5;
  localparam int SEC_REDUNDANT = 7;
  localparam int SEC_LOCK0 = 8;
  localparam int SEC_MASTER_LOCK = 12;
  localparam int SEC_JTAG_OTP_DIS = 13;
  localparam int SEC_GP_LSB = 15;
  localparam int SEC_GP_MSB = 21;
  localparam int SEC_UID_LSB = 22;
  localparam int SEC_UID_MSB = 31;
  // Bits with an assigned function or field; all others read as zero.
  localparam logic [31:0] SEC_USED_MASK = 32'hFFFF_BFA3;
  localparam logic [31:0] SEC_RESET = 32'h0000_0000;
  // Scan port sizes and instruction codes.
  localparam int IR_W = 4;
  localparam int DR_W = 32;
  localparam logic [3:0] IR_EXTEST = 4'h0;
  localparam logic [3:0] IR_SCAN_IDENTIFICATION_WORD = 4'h1;
  localparam logic [3:0] IR_USERCODE = 4'h2;
  localparam logic [3:0] IR_SAMPLE = 4'h3;
  localparam logic [3:0] IR_CHIP = 4'h4;
  localparam logic [3:0] IR_OTP_ADDR = 4'h5;
  localparam logic [3:0] IR_OTP_DATA = 4'h6;
  localparam logic [3:0] IR_BYPASS = 4'hF;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [2:0] TMS_RESET_CYCLES = 3'h5;
  // Boot sequencer states.
  typedef enum logic [1:0] {
    BOOT_LOAD = 2'h0,
    BOOT_COPY = 2'h1,
    BOOT_DONE = 2'h2
  } boot_t;
  // Test access port controller states.
  typedef enum logic [3:0] {
    TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h2, CAP_DR = 4'h3,
    SH_DR = 4'h4, EX1_DR = 4'h5, PA_DR = 4'h6, EX2_DR = 4'h7,
    UP_DR = 4'h8, SEL_IR = 4'h9, CAP_IR = 4'hA, SH_IR = 4'hB,
    EX1_IR = 4'hC, PA_IR = 4'hD, EX2_IR = 4'hE, UP_IR = 4'hF
  } tap_t;
endpackage : otp_sec_pkg

// File: hw/otp_security_jtag_id.sv
// Store, security word, boot copy and boundary-scan port of one tile.
`timescale 1ns/1ns
// Summary of operation
// - Store has four sectors, each 512 rows of 32-bit words.
// - Security word is loaded from the store at power-up before use.
// - Remaining store contents are copied to SRAM, then the core starts.
// - Bit 0 disables the scan interface entirely.
// - Bit 1 refuses link access; bits 0 and 1 together isolate the tile.
// - Bit 5 makes the tile boot from store address 0.
// - Bit 7 enables redundant row substitution in the store.
// - Bits 8 to 11 each lock programming of sectors 0 to 3.
// - Bit 12 rejects all programming, security word included.
// - Bit 13 blocks scan reads and writes of the store.
// - Bits 21 to 15 form a free general-purpose software field.
// - Bits 31 to 22 hold a user identifier shown in the user code.
// - Five cycles of TMS high return the scan logic to reset.
// - A chained second test port reaches the tile for load and debug.
// - SCAN_IDENTIFICATION_WORD returns version, part and maker fields with bit 0 set.
// - USERCODE returns identifier, unused field and silicon revision.
module otp_security_jtag_id #(
  parameter int BSR_W = 8,
  parameter logic [3:0] ID_VERSION = 4'h0,
  parameter logic [15:0] ID_PART = 16'h1234,  // Arbitrary value.
  parameter logic [10:0] ID_MAKER = 11'h2AB,  // Arbitrary value.
  parameter logic [17:0] SILICON_REV = 18'h00001  // Arbitrary value.
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] otp_addr_port,
  input wire logic [31:0] otp_data_port,
  input wire logic [15:0] otp_ctl_port,
  input wire logic otp_ctl_strobe,
  output logic [31:0] otp_rdata,
  output logic prog_done,
  output logic prog_err,
  output logic [31:0] security_word,
  output logic link_access_en,
  output logic tile_isolated,
  output logic redundant_rows_en,
  output logic boot_from_otp,
  output logic sram_we,
  output logic [10:0] sram_addr,
  output logic [31:0] sram_data,
  output logic core_start,
  output logic boot_done,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [BSR_W-1:0] pin_in,
  output logic [BSR_W-1:0] pin_out,
  output logic pin_extest,
  output logic chip_sel,
  output logic chip_tdi,
  input wire logic chip_tdo
);
  localparam logic [31:0] SCAN_IDENTIFICATION_WORD_WORD = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

  // Tile clock domain state.
  typedef struct packed {
    otp_sec_pkg::boot_t boot;
    logic [11:0] idx;
    logic [31:0] sec;
    logic sec_loaded;
    logic sram_we;
    logic [10:0] sram_addr;
    logic [31:0] sram_data;
    logic core_start;
    logic prog_done;
    logic prog_err;
    logic [31:0] rdata;
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic ack;
    logic [31:0] jdata;
  } core_st_t;

  // Scan clock domain state.
  typedef struct packed {
    otp_sec_pkg::tap_t tap;
    logic [3:0] ir;
    logic [3:0] ir_sh;
    logic [31:0] dr_sh;
    logic [2:0] tms_cnt;
    logic rst_s1;
    logic rst_s2;
    logic dis_s1;
    logic dis_s2;
    logic blk_s1;
    logic blk_s2;
    logic ld_s1;
    logic ld_s2;
    logic [9:0] uid;
    logic [BSR_W-1:0] pin_s1;
    logic [BSR_W-1:0] pin_s2;
    logic [BSR_W-1:0] pin_out;
    logic extest;
    logic chip_tdi;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic req;
    logic ack_s1;
    logic ack_s2;
    logic ack_seen;
    logic [31:0] rdata;
  } scan_st_t;

  core_st_t c_q, c_d;
  scan_st_t s_q, s_d;
  logic tdo_q;
  // Fuses start unprogrammed; a write can only turn bits on.
  logic [31:0] otp_mem [0:otp_sec_pkg::DATA_WORDS] =
    '{default: 32'h0000_0000};
  logic mem_we;
  logic [11:0] mem_addr;
  logic [31:0] mem_wdata;

  // Lock decode shared by the software and scan write paths.
  function automatic logic write_locked(input logic [31:0] sec,
                                        input logic [11:0] row);
    logic lk;
    lk = sec[otp_sec_pkg::SEC_MASTER_LOCK];
    if (row > otp_sec_pkg::SEC_ROW) begin
      lk = 1'b1;
    end else if (row != otp_sec_pkg::SEC_ROW) begin
      lk = lk | sec[otp_sec_pkg::SEC_LOCK0 + int'(row[10:9])];
    end
    return lk;
  endfunction : write_locked

  // Programming ORs the new bits into the addressed row.
  always_ff @(posedge clk) begin
    if (mem_we) begin
      otp_mem[mem_addr] <= otp_mem[mem_addr] | mem_wdata;
    end
  end

  // Tile side: boot load and copy, then programming from port or scan.
  always_comb begin
    logic [11:0] row;
    logic [11:0] jrow;
    row = otp_addr_port[11:0];
    jrow = s_q.addr;
    c_d = c_q;
    mem_we = 1'b0;
    mem_addr = row;
    mem_wdata = otp_data_port;
    c_d.sram_we = 1'b0;
    c_d.core_start = 1'b0;
    c_d.prog_done = 1'b0;
    c_d.prog_err = 1'b0;
    c_d.req_s1 = s_q.req;
    c_d.req_s2 = c_q.req_s1;
    case (c_q.boot)
      otp_sec_pkg::BOOT_LOAD: begin
        // Unassigned bits are dropped here so nothing downstream sees them.
        c_d.sec = otp_mem[otp_sec_pkg::SEC_ROW] &
                  otp_sec_pkg::SEC_USED_MASK;
        c_d.sec_loaded = 1'b1;
        c_d.idx = 12'h000;
        c_d.boot = otp_sec_pkg::BOOT_COPY;
      end
      otp_sec_pkg::BOOT_COPY: begin
        c_d.sram_we = 1'b1;
        c_d.sram_addr = c_q.idx[10:0];
        c_d.sram_data = otp_mem[c_q.idx];
        c_d.idx = c_q.idx + 12'h001;
        if (c_q.idx == otp_sec_pkg::LAST_ROW) begin
          c_d.core_start = 1'b1;
          c_d.boot = otp_sec_pkg::BOOT_DONE;
        end
      end
      otp_sec_pkg::BOOT_DONE: begin
        if (otp_ctl_strobe) begin
          c_d.prog_done = 1'b1;
          if (otp_addr_port[15:12] != 4'h0) begin
            c_d.prog_err = 1'b1;
          end else if (otp_ctl_port[otp_sec_pkg::CTL_PROG_SEC]) begin
            // The running copy changes only at the next reset.
            if (c_q.sec[otp_sec_pkg::SEC_MASTER_LOCK]) begin
              c_d.prog_err = 1'b1;
            end else begin
              mem_we = 1'b1;
              mem_addr = otp_sec_pkg::SEC_ROW;
            end
          end else if (otp_ctl_port[otp_sec_pkg::CTL_PROG]) begin
            if (write_locked(c_q.sec, row) ||
                row == otp_sec_pkg::SEC_ROW) begin
              c_d.prog_err = 1'b1;
            end else begin
              mem_we = 1'b1;
            end
          end else if (otp_ctl_port[otp_sec_pkg::CTL_READ]) begin
            c_d.rdata = (row > otp_sec_pkg::SEC_ROW) ? 32'h0000_0000 :
                        otp_mem[row];
          end else begin
            c_d.prog_err = 1'b1;
          end
        end else if (c_q.req_s2 != c_q.req_seen) begin
          // Scan request; its payload is held steady until we answer.
          c_d.req_seen = c_q.req_s2;
          c_d.jdata = (jrow > otp_sec_pkg::SEC_ROW) ? 32'h0000_0000 :
                      otp_mem[jrow];
          if (c_q.sec[otp_sec_pkg::SEC_JTAG_OTP_DIS]) begin
            c_d.jdata = 32'h0000_0000;
          end else if (s_q.wr && !write_locked(c_q.sec, jrow)) begin
            mem_we = 1'b1;
            mem_addr = jrow;
            mem_wdata = s_q.wdata;
          end
          c_d.ack = ~c_q.ack;
        end
      end
      default: begin
        c_d.boot = otp_sec_pkg::BOOT_LOAD;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      c_q <= '0;
      c_q.boot <= otp_sec_pkg::BOOT_LOAD;
      c_q.sec <= otp_sec_pkg::SEC_RESET;
    end else begin
      c_q <= c_d;
    end
  end

  // Scan side: controller, instruction and data registers.
  always_comb begin
    logic rst_t;
    logic busy;
    rst_t = s_q.rst_s2 | s_q.dis_s2;
    busy = s_q.req != s_q.ack_s2;
    s_d = s_q;
    s_d.rst_s1 = rst;
    s_d.rst_s2 = s_q.rst_s1;
    s_d.dis_s1 = c_q.sec[otp_sec_pkg::SEC_JTAG_DIS];
    s_d.dis_s2 = s_q.dis_s1;
    s_d.blk_s1 = c_q.sec[otp_sec_pkg::SEC_JTAG_OTP_DIS];
    s_d.blk_s2 = s_q.blk_s1;
    s_d.ld_s1 = c_q.sec_loaded;
    s_d.ld_s2 = s_q.ld_s1;
    s_d.pin_s1 = pin_in;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.ack_s1 = c_q.ack;
    s_d.ack_s2 = s_q.ack_s1;
    s_d.chip_tdi = tdi;
    // The word is stable once loaded, so the level flag guards its capture.
    if (s_q.ld_s2) begin
      s_d.uid = c_q.sec[otp_sec_pkg::SEC_UID_MSB:
                        otp_sec_pkg::SEC_UID_LSB];
    end
    if (s_q.ack_s2 != s_q.ack_seen) begin
      s_d.ack_seen = s_q.ack_s2;
      s_d.rdata = c_q.jdata;
    end
    s_d.tms_cnt = tms ? ((s_q.tms_cnt == otp_sec_pkg::TMS_RESET_CYCLES) ?
                  s_q.tms_cnt : s_q.tms_cnt + 3'h1) : 3'h0;
    case (s_q.tap)
      otp_sec_pkg::TLR:
        s_d.tap = tms ? otp_sec_pkg::TLR : otp_sec_pkg::RTI;
      otp_sec_pkg::RTI:
        s_d.tap = tms ? otp_sec_pkg::SEL_DR : otp_sec_pkg::RTI;
      otp_sec_pkg::SEL_DR:
        s_d.tap = tms ? otp_sec_pkg::SEL_IR : otp_sec_pkg::CAP_DR;
      otp_sec_pkg::CAP_DR:
        s_d.tap = tms ? otp_sec_pkg::EX1_DR : otp_sec_pkg::SH_DR;
      otp_sec_pkg::SH_DR:
        s_d.tap = tms ? otp_sec_pkg::EX1_DR : otp_sec_pkg::SH_DR;
      otp_sec_pkg::EX1_DR:
        s_d.tap = tms ? otp_sec_pkg::UP_DR : otp_sec_pkg::PA_DR;
      otp_sec_pkg::PA_DR:
        s_d.tap = tms ? otp_sec_pkg::EX2_DR : otp_sec_pkg::PA_DR;
      otp_sec_pkg::EX2_DR:
        s_d.tap = tms ? otp_sec_pkg::UP_DR : otp_sec_pkg::SH_DR;
      otp_sec_pkg::UP_DR:
        s_d.tap = tms ? otp_sec_pkg::SEL_DR : otp_sec_pkg::RTI;
      otp_sec_pkg::SEL_IR:
        s_d.tap = tms ? otp_sec_pkg::TLR : otp_sec_pkg::CAP_IR;
      otp_sec_pkg::CAP_IR:
        s_d.tap = tms ? otp_sec_pkg::EX1_IR : otp_sec_pkg::SH_IR;
      otp_sec_pkg::SH_IR:
        s_d.tap = tms ? otp_sec_pkg::EX1_IR : otp_sec_pkg::SH_IR;
      otp_sec_pkg::EX1_IR:
        s_d.tap = tms ? otp_sec_pkg::UP_IR : otp_sec_pkg::PA_IR;
      otp_sec_pkg::PA_IR:
        s_d.tap = tms ? otp_sec_pkg::EX2_IR : otp_sec_pkg::PA_IR;
      otp_sec_pkg::EX2_IR:
        s_d.tap = tms ? otp_sec_pkg::UP_IR : otp_sec_pkg::SH_IR;
      otp_sec_pkg::UP_IR:
        s_d.tap = tms ? otp_sec_pkg::SEL_DR : otp_sec_pkg::RTI;
      default: s_d.tap = otp_sec_pkg::TLR;
    endcase
    case (s_q.tap)
      otp_sec_pkg::CAP_IR: s_d.ir_sh = otp_sec_pkg::IR_CAPTURE;
      otp_sec_pkg::SH_IR: s_d.ir_sh = {tdi, s_q.ir_sh[3:1]};
      otp_sec_pkg::UP_IR: s_d.ir = s_q.ir_sh;
      otp_sec_pkg::CAP_DR: begin
        case (s_q.ir)
          otp_sec_pkg::IR_SCAN_IDENTIFICATION_WORD: s_d.dr_sh = SCAN_IDENTIFICATION_WORD_WORD;
          otp_sec_pkg::IR_USERCODE:
            s_d.dr_sh = {s_q.uid, 4'h0, SILICON_REV};
          otp_sec_pkg::IR_EXTEST, otp_sec_pkg::IR_SAMPLE:
            s_d.dr_sh = {{(32 - BSR_W){1'b0}}, s_q.pin_s2};
          otp_sec_pkg::IR_OTP_DATA:
            s_d.dr_sh = s_q.blk_s2 ? 32'h0000_0000 : s_q.rdata;
          default: s_d.dr_sh = 32'h0000_0000;
        endcase
      end
      otp_sec_pkg::SH_DR: begin
        // Shift length follows the selected register.
        case (s_q.ir)
          otp_sec_pkg::IR_EXTEST, otp_sec_pkg::IR_SAMPLE: begin
            s_d.dr_sh = s_q.dr_sh >> 1;
            s_d.dr_sh[BSR_W-1] = tdi;
          end
          otp_sec_pkg::IR_SCAN_IDENTIFICATION_WORD, otp_sec_pkg::IR_USERCODE,
          otp_sec_pkg::IR_OTP_ADDR, otp_sec_pkg::IR_OTP_DATA:
            s_d.dr_sh = {tdi, s_q.dr_sh[31:1]};
          default: s_d.dr_sh = {31'h0000_0000, tdi};
        endcase
      end
      otp_sec_pkg::UP_DR: begin
        if (s_q.ir == otp_sec_pkg::IR_EXTEST) begin
          s_d.pin_out = s_q.dr_sh[BSR_W-1:0];
        end
        // A busy or blocked store access is dropped without effect.
        if (!busy && !s_q.blk_s2) begin
          if (s_q.ir == otp_sec_pkg::IR_OTP_ADDR) begin
            s_d.addr = s_q.dr_sh[11:0];
            s_d.wr = 1'b0;
            s_d.req = ~s_q.req;
          end else if (s_q.ir == otp_sec_pkg::IR_OTP_DATA) begin
            s_d.wdata = s_q.dr_sh;
            s_d.wr = 1'b1;
            s_d.req = ~s_q.req;
          end
        end
      end
      default: begin
      end
    endcase
    s_d.extest = s_q.ir == otp_sec_pkg::IR_EXTEST;
    // The fifth high TMS edge resets at once; a later low edge must walk on.
    if (rst_t || s_d.tms_cnt == otp_sec_pkg::TMS_RESET_CYCLES) begin
      s_d.tap = otp_sec_pkg::TLR;
      s_d.ir = otp_sec_pkg::IR_SCAN_IDENTIFICATION_WORD;
      s_d.extest = 1'b0;
    end
  end

  always_ff @(posedge tck) begin
    s_q <= s_d;
  end

  // Data leaves on the falling edge so the host samples it mid-cycle.
  always_ff @(negedge tck) begin
    if (s_q.tap == otp_sec_pkg::SH_IR) begin
      tdo_q <= s_q.ir_sh[0];
    end else if (s_q.ir == otp_sec_pkg::IR_CHIP) begin
      tdo_q <= chip_tdo;
    end else begin
      tdo_q <= s_q.dr_sh[0];
    end
  end

  assign otp_rdata = c_q.rdata;
  assign prog_done = c_q.prog_done;
  assign prog_err = c_q.prog_err;
  assign security_word = c_q.sec;
  assign link_access_en = ~c_q.sec[otp_sec_pkg::SEC_LINK_DIS];
  assign tile_isolated = c_q.sec[otp_sec_pkg::SEC_LINK_DIS] &
                         c_q.sec[otp_sec_pkg::SEC_JTAG_DIS];
  assign redundant_rows_en = c_q.sec[otp_sec_pkg::SEC_REDUNDANT];
  assign boot_from_otp = c_q.sec[otp_sec_pkg::SEC_BOOT_OTP];
  assign sram_we = c_q.sram_we;
  assign sram_addr = c_q.sram_addr;
  assign sram_data = c_q.sram_data;
  assign core_start = c_q.core_start;
  assign boot_done = c_q.boot == otp_sec_pkg::BOOT_DONE;
  assign tdo = tdo_q;
  assign tdo_oe = (s_q.tap == otp_sec_pkg::SH_DR ||
                   s_q.tap == otp_sec_pkg::SH_IR) &&
                  !s_q.dis_s2;
  assign pin_out = s_q.pin_out;
  assign pin_extest = s_q.extest;
  assign chip_sel = s_q.ir == otp_sec_pkg::IR_CHIP;
  assign chip_tdi = s_q.chip_tdi;
endmodule : otp_security_jtag_id

// File: bench/otp_sec_sva.sv
// Concurrent checks on the store, boot copy and security outputs.
`timescale 1ns/1ns
module otp_sec_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic otp_ctl_strobe,
  input wire logic prog_done,
  input wire logic prog_err,
  input wire logic [31:0] security_word,
  input wire logic link_access_en,
  input wire logic tile_isolated,
  input wire logic redundant_rows_en,
  input wire logic boot_from_otp,
  input wire logic sram_we,
  input wire logic [10:0] sram_addr,
  input wire logic core_start,
  input wire logic boot_done,
  input wire logic tdo_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // A strobe counts only once the boot copy has finished.
  sequence s_take;
    otp_ctl_strobe && boot_done;
  endsequence
  sequence s_last_word;
    sram_we && sram_addr == 11'h7FF;
  endsequence
  property p_answer; s_take |-> ##[1:2] prog_done; endproperty
  a_answer: assert property (p_answer) else $error("strobe unanswered");
  property p_err; prog_err |-> prog_done; endproperty
  a_err: assert property (p_err) else $error("refusal without done");
  property p_idle; !boot_done |-> !prog_done; endproperty
  a_idle: assert property (p_idle) else $error("answer during boot");
  property p_end; core_start |-> s_last_word ##1 boot_done; endproperty
  a_end: assert property (p_end) else $error("copy end wrong");
  // Copy addresses must climb by one with no gap until the last row.
  property p_run;
    sram_we && sram_addr != 11'h7FF |=>
      sram_we && sram_addr == $past(sram_addr) + 11'h1;
  endproperty
  a_run: assert property (p_run) else $error("copy gap");
  property p_link; boot_done |-> link_access_en == !security_word[1];
  endproperty
  a_link: assert property (p_link) else $error("link gate wrong");
  property p_iso;
    boot_done |-> tile_isolated == (security_word[0] && security_word[1]);
  endproperty
  a_iso: assert property (p_iso) else $error("isolation wrong");
  property p_red; boot_done |-> redundant_rows_en == security_word[7];
  endproperty
  a_red: assert property (p_red) else $error("redundant wrong");
  property p_boot; boot_done |-> boot_from_otp == security_word[5];
  endproperty
  a_boot: assert property (p_boot) else $error("boot select wrong");
  property p_unused;
    (security_word & ~otp_sec_pkg::SEC_USED_MASK) == 32'h0;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bit set");
  // The word is latched at boot; programming shows only after reset.
  property p_hold;
    boot_done && $past(boot_done) |-> $stable(security_word);
  endproperty
  a_hold: assert property (p_hold) else $error("word changed");
  property p_scan_off; boot_done && security_word[0] |-> !tdo_oe;
  endproperty
  a_scan_off: assert property (p_scan_off) else $error("scan active");
endmodule : otp_sec_sva
bind otp_security_jtag_id otp_sec_sva u_sva (.clk, .rst, .otp_ctl_strobe,
  .prog_done, .prog_err, .security_word, .link_access_en, .tile_isolated,
  .redundant_rows_en, .boot_from_otp, .sram_we, .sram_addr, .core_start,
  .boot_done, .tdo_oe);

// File: bench/scan_host.sv
// Scan host model that clocks frames into the test access port.
`timescale 1ns/1ns
module scan_host (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe,
  output logic oe_seen
);
  // The scan clock stands low between frames.
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    oe_seen = 1'b0;
  end
  // One 15 ns scan clock; tdo is taken before the rising edge because
  // the port moves it on the falling edge.
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #7;
    o = tdo;
    if (tdo_oe === 1'b1) oe_seen = 1'b1;
    tck = 1'b1;
    #8;
    tck = 1'b0;
  endtask : step
  // Reset the port, optionally load an instruction, then scan 32 bits.
  task automatic scan(input logic ir_en, input logic [3:0] ir,
                      output logic [31:0] q);
    logic o;
    q = 32'h0;
    oe_seen = 1'b0;
    for (int i = 0; i < 5; i++) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    if (ir_en) begin
      step(1'b1, 1'b0, o);
      step(1'b1, 1'b0, o);
      step(1'b0, 1'b0, o);
      step(1'b0, 1'b0, o);
      for (int i = 0; i < 4; i++) step(i == 3, ir[i], o);
      step(1'b1, 1'b0, o);
      step(1'b0, 1'b0, o);
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < 32; i++) begin
      step(i == 31, 1'b0, o);
      q[i] = o;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    tdi = 1'b1;
  endtask : scan
endmodule : scan_host

// File: bench/tb_otp_security_jtag_id.sv
// Self-checking bench for the tile store, security word and scan port.
`timescale 1ns/1ns
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_otp_security_jtag_id;
  localparam logic [3:0] VER = 4'h3;
  localparam logic [15:0] PART = 16'h5A5A;  // Arbitrary value.
  localparam logic [10:0] MAKER = 11'h155;  // Arbitrary value.
  localparam logic [17:0] REV = 18'h00042;  // Arbitrary value.
  logic clk, rst, strobe, chip_tdo, tck, tms, tdi, oe_seen, tdo, tdo_oe;
  logic prog_done, prog_err, link_en, iso, red_en, boot_otp, sram_we;
  logic core_start, boot_done;
  logic [15:0] addr, ctl, a;
  logic [31:0] data, rdata, sec_w, sec_f, sec_r, q, s, sram_data;
  logic [7:0] pin_in;
  logic [10:0] sram_addr;
  logic [31:0] mem [2048];
  int bad_count, check_count;
  otp_security_jtag_id #(.BSR_W(8), .ID_VERSION(VER), .ID_PART(PART),
    .ID_MAKER(MAKER), .SILICON_REV(REV)) dut (.clk(clk), .rst(rst),
    .otp_addr_port(addr), .otp_data_port(data), .otp_ctl_port(ctl),
    .otp_ctl_strobe(strobe), .otp_rdata(rdata), .prog_done(prog_done),
    .prog_err(prog_err), .security_word(sec_w), .link_access_en(link_en),
    .tile_isolated(iso), .redundant_rows_en(red_en),
    .boot_from_otp(boot_otp), .sram_we(sram_we), .sram_addr(sram_addr),
    .sram_data(sram_data), .core_start(core_start), .boot_done(boot_done),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .pin_in(pin_in), .pin_out(), .pin_extest(), .chip_sel(), .chip_tdi(),
    .chip_tdo(chip_tdo));
  scan_host u_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .oe_seen(oe_seen));
  // Tile clock of 8 ns.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Boundary pins and the chained port's output carry random traffic.
  always @(posedge clk) begin
    pin_in <= 8'($urandom);
    chip_tdo <= 1'($urandom);
  end
  task automatic report_and_stop();
    if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  // Reset, then follow the copy word by word against the fuse model.
  // Expected read result: data rows, the raw security row, else zero.
  function automatic logic [31:0] rd_exp(input logic [11:0] r);
    if (r > 12'h800) return 32'h0;
    return r[11] ? sec_f : mem[r[10:0]];
  endfunction : rd_exp
  task automatic boot();
    int n;
    logic o;
    n = 0;
    @(posedge clk) rst <= 1'b1;
    // The scan side sees reset only on its own clock, so tick it meanwhile.
    fork
      repeat (10) @(posedge clk);
      repeat (4) u_host.step(1'b1, 1'b0, o);
    join
    `CHK(link_en, 1'b1)
    `CHK(sec_w, 32'h0)
    rst <= 1'b0;
    for (int k = 0; k < 3000; k++) begin
      @(posedge clk);
      #1;
      if (sram_we === 1'b1) begin
        `CHK(sram_data, mem[sram_addr])
        n++;
      end
      if (boot_done === 1'b1) break;
      if (k == 2999) begin
        bad_count++;
        report_and_stop();
      end
    end
    `CHK(n, 2048)
    sec_r = sec_f & otp_sec_pkg::SEC_USED_MASK;
    `CHK(sec_w, sec_r)
  endtask : boot
  // One port request; the refusal expected follows the running word.
  task automatic prog(input logic [15:0] pa, input logic [31:0] pd,
                      input logic [15:0] pc);
    logic e;
    // A read beyond the security row is not refused; it returns zero.
    e = pa[15:12] != 4'h0;
    if (pc[1]) e = e | sec_r[12];
    else if (pc[0]) e = e | sec_r[12] | pa[11] | sec_r[8 + pa[10:9]];
    else if (!pc[2]) e = 1'b1;
    @(posedge clk);
    addr <= pa;
    data <= pd;
    ctl <= pc;
    strobe <= 1'b1;
    @(posedge clk);
    strobe <= 1'b0;
    #1;
    for (int k = 0; prog_done !== 1'b1; k++) begin
      if (k == 4) begin
        bad_count++;
        report_and_stop();
      end
      @(posedge clk);
      #1;
    end
    `CHK(prog_err, e)
    if (!e && pc[1]) sec_f = sec_f | pd;
    else if (!e && pc[0]) mem[pa[10:0]] = mem[pa[10:0]] | pd;
    else if (!e && pc[2]) `CHK(rdata, rd_exp(pa[11:0]))
  endtask : prog
  // Main sequence: identity, store traffic, then the sector 1 and scan locks, then the master lock.
  initial begin
    void'($urandom(8088));
    rst = 1'b1;
    strobe = 1'b0;
    addr = 16'h0;
    data = 32'h0;
    ctl = 16'h0;
    sec_f = 32'h0;
    sec_r = 32'h0;
    foreach (mem[i]) mem[i] = 32'h0;
    boot();
    u_host.scan(1'b0, 4'h0, q);
    `CHK(q, {VER, PART, MAKER, 1'b1})
    u_host.scan(1'b1, otp_sec_pkg::IR_USERCODE, q);
    `CHK(q, {10'h0, 4'h0, REV})
    u_host.scan(1'b0, 4'h0, q);
    `CHK(q, {VER, PART, MAKER, 1'b1})
    for (int i = 0; i < 8; i++) begin
      a = {5'h0, 2'(i), 9'($urandom)};
      prog(a, $urandom, 16'h0001);
      prog(a, 32'h0, 16'h0004);
    end
    // Row 0 read back through the scan port while access is open.
    prog(16'h0000, $urandom, 16'h0001);
    u_host.scan(1'b1, otp_sec_pkg::IR_OTP_ADDR, q);
    u_host.scan(1'b1, otp_sec_pkg::IR_OTP_DATA, q);
    `CHK(q, mem[0])
    prog(16'h1000, 32'h1, 16'h0001);
    prog(16'h0801, 32'h1, 16'h0004);
    prog(16'h0000, 32'h1, 16'h0000);
    prog(16'h0800, 32'h1, 16'h0001);
    s = ($urandom & 32'hFFFF_8000) | 32'h0000_22FE;
    prog(16'h0800, s, 16'h0002);
    boot();
    `CHK(link_en, 1'b0)
    `CHK(boot_otp, 1'b1)
    `CHK(red_en, 1'b1)
    u_host.scan(1'b1, otp_sec_pkg::IR_USERCODE, q);
    `CHK(q, {s[31:22], 4'h0, REV})
    prog(16'h0200, 32'h5, 16'h0001);
    prog(16'h0000, 32'h5, 16'h0001);
    u_host.scan(1'b1, otp_sec_pkg::IR_OTP_ADDR, q);
    u_host.scan(1'b1, otp_sec_pkg::IR_OTP_DATA, q);
    `CHK(q, 32'h0)
    prog(16'h0800, 32'h1001, 16'h0002);
    boot();
    `CHK(iso, 1'b1)
    prog(16'h0600, 32'h1, 16'h0001);
    prog(16'h0800, 32'h2, 16'h0002);
    u_host.scan(1'b0, 4'h0, q);
    `CHK(oe_seen, 1'b0)
    report_and_stop();
  end
endmodule : tb_otp_security_jtag_id
